// [sbd_cmd_check.sv]
// Field split and parity check of one received command frame.
`timescale 1ns/100ps
module sbd_cmd_check (
    input wire logic [sbd_pkg::FRAME_BITS-1:0] frame,
    input wire logic parity_en,
    output sbd_pkg::sbd_cmd_t cmd_type,
    output logic [4:0] reg_addr,
    output logic [sbd_pkg::BYTE_W-1:0] payload,
    output logic sub_sel,
    output logic addr_valid,
    output logic parity_ok
);
    import sbd_pkg::*;

    assign cmd_type = sbd_cmd_t'(frame[TYPE_HI:TYPE_LO]);
    assign reg_addr = frame[ADDR_HI:ADDR_LO];
    assign payload = frame[BYTE_W-1:0];
    assign sub_sel = frame[SUB_BIT];
    assign addr_valid = (frame[ADDR_HI:ADDR_LO] <= ADDR_LIN_CTRL);
    // odd total ones
    // With bit 8 included a correct frame always holds an odd number of ones.
    assign parity_ok = !parity_en || (^frame);

endmodule : sbd_cmd_check

// [sbd_decoder.sv]
// Serial 16-bit command frame decoder with register file and status return.
// Functional notes
// - Frame bits 13 to 9 alone select the target register.
// - Addresses 1 to 4 are scratch bytes that store and return data.
// - Addresses 5 to 8 are initialisation registers, written and read back.
// - Address 9 write picks special mode; read returns the random code.
// - Addresses 10 to 12 are timer registers, written and read back.
// - Address 14 write selects mode; read returns mode and leaves debug.
// - Addresses 15 to 19 store control bits and also supply flags.
// - Type 00 with bit 7 low returns status then control bits.
// - Type 00 with bit 7 high returns status then device information.
// - Type 01 stores payload and returns fixed and extended status.
// - Type 11 returns flags; bit 7 picks low or high set.
// - Parity is checked only on type 01 writes.
// - Bit 6 of miscellaneous init register enables parity checking.
// - First returned byte is always the fixed device status.
`timescale 1ns/100ps
module sbd_decoder (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [sbd_pkg::BYTE_W-1:0] fixed_status,
    input wire logic [sbd_pkg::BYTE_W-1:0] extended_status,
    input wire logic [sbd_pkg::BYTE_W-1:0] device_info,
    input wire logic [sbd_pkg::BYTE_W-1:0] random_code,
    input wire logic [sbd_pkg::BYTE_W-1:0] current_mode,
    input wire logic [sbd_pkg::FLAGS_W-1:0] flag_low,
    input wire logic [sbd_pkg::FLAGS_W-1:0] flag_high,
    output logic [sbd_pkg::REGS_W-1:0] reg_file,
    output logic [sbd_pkg::BYTE_W-1:0] command_data,
    output logic watchdog_refresh,
    output logic special_mode_write,
    output logic mode_write,
    output logic debug_exit,
    output logic parity_error,
    output logic frame_error
);
    import sbd_pkg::*;

    typedef struct packed {
        logic sclk_prev;
        logic cs_prev;
        logic [FRAME_BITS-1:0] frame;
        logic [CNT_W-1:0] cnt;
        logic [FRAME_BITS-1:0] miso_sh;
        logic [BYTE_W-1:0] resp;
        logic [NUM_REGS-1:0][BYTE_W-1:0] regs;
        logic [BYTE_W-1:0] cmd_data;
        logic miso;
        logic miso_oe;
        logic wd_pulse;
        logic spe_pulse;
        logic mode_pulse;
        logic dbg_pulse;
        logic par_err;
        logic frm_err;
    } sbd_state_t;

    sbd_state_t state_q;
    sbd_state_t state_d;

    logic [2:0] pins_s;
    logic sclk_s;
    logic cs_s;
    logic mosi_s;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_full;
    sbd_cmd_t cmd_type;
    logic [4:0] reg_addr;
    logic [BYTE_W-1:0] payload;
    logic sub_sel;
    logic addr_valid;
    logic parity_ok;
    logic [4:0] flag_off;
    logic [5:0] flag_pos;
    logic is_flag_reg;

    // Chip select idles high, so the synchroniser starts there to avoid a false frame start.
    sbd_sync2 #(
        .W(3),
        .INIT(3'h2)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in({spi_sclk, spi_cs_n, spi_mosi}),
        .sync_out(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_s = pins_s[1];
    assign mosi_s = pins_s[0];

    sbd_cmd_check u_check (
        .frame(state_q.frame),
        .parity_en(state_q.regs[ADDR_INIT_MISC][PARITY_EN_BIT]),
        .cmd_type(cmd_type),
        .reg_addr(reg_addr),
        .payload(payload),
        .sub_sel(sub_sel),
        .addr_valid(addr_valid),
        .parity_ok(parity_ok)
    );

    assign cs_fall = state_q.cs_prev && !cs_s;
    assign cs_rise = !state_q.cs_prev && cs_s;
    assign sclk_rise = !state_q.sclk_prev && sclk_s && !cs_s;
    assign sclk_fall = state_q.sclk_prev && !sclk_s && !cs_s;
    assign frame_full = (state_q.cnt == FRAME_LEN);
    assign flag_off = reg_addr - ADDR_REGULATOR_CTRL;
    assign flag_pos = {flag_off[2:0], 3'h0};
    assign is_flag_reg = (reg_addr >= ADDR_REGULATOR_CTRL) && addr_valid;

    always_comb begin
        state_d = state_q;
        state_d.sclk_prev = sclk_s;
        state_d.cs_prev = cs_s;
        state_d.wd_pulse = 1'b0;
        state_d.spe_pulse = 1'b0;
        state_d.mode_pulse = 1'b0;
        state_d.dbg_pulse = 1'b0;
        state_d.par_err = 1'b0;
        state_d.frm_err = 1'b0;
        if (cs_fall) begin
            state_d.cnt = '0;
            state_d.miso_sh = {fixed_status, state_q.resp};
            state_d.miso = fixed_status[BYTE_W-1];
            state_d.miso_oe = 1'b1;
        end else if (sclk_rise) begin
            state_d.miso = state_q.miso_sh[FRAME_BITS-1];
            state_d.miso_sh = {state_q.miso_sh[FRAME_BITS-2:0], 1'b0};
        end else if (sclk_fall) begin
            state_d.frame = {state_q.frame[FRAME_BITS-2:0], mosi_s};
            if (state_q.cnt != CNT_SAT) begin
                state_d.cnt = state_q.cnt + 5'h01;
            end
        end else if (cs_rise) begin
            state_d.miso_oe = 1'b0;
            state_d.miso = 1'b0;
            if (!frame_full) begin
                state_d.frm_err = 1'b1;
            end else begin
                unique case (cmd_type)
                    CMD_WRITE: begin
                        state_d.resp = extended_status;
                        if (!parity_ok) begin
                            state_d.par_err = 1'b1;
                        end else if (addr_valid) begin
                            state_d.cmd_data = payload;
                            if (reg_addr == ADDR_SPECIAL_MODE) begin
                                state_d.spe_pulse = 1'b1;
                            end else if (reg_addr == ADDR_WATCHDOG_REFRESH) begin
                                state_d.wd_pulse = 1'b1;
                            end else begin
                                state_d.regs[reg_addr] = payload;
                                state_d.mode_pulse = (reg_addr == ADDR_MODE);
                            end
                        end
                    end
                    CMD_READ: begin
                        if (sub_sel) begin
                            state_d.resp = device_info;
                        end else if (reg_addr == ADDR_SPECIAL_MODE) begin
                            state_d.resp = random_code;
                        end else if (reg_addr == ADDR_MODE) begin
                            state_d.resp = current_mode;
                            state_d.dbg_pulse = 1'b1;
                        end else if (addr_valid && reg_addr != ADDR_WATCHDOG_REFRESH) begin
                            state_d.resp = state_q.regs[reg_addr];
                        end else begin
                            state_d.resp = REG_RESET;
                        end
                    end
                    CMD_FLAG: begin
                        if (!is_flag_reg) begin
                            state_d.resp = REG_RESET;
                        end else if (sub_sel) begin
                            state_d.resp = flag_high[flag_pos +: BYTE_W];
                        end else begin
                            state_d.resp = flag_low[flag_pos +: BYTE_W];
                        end
                    end
                    CMD_RSVD: begin
                        state_d.resp = REG_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= '0;
            state_q.cs_prev <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign spi_miso = state_q.miso;
    assign spi_miso_oe = state_q.miso_oe;
    assign reg_file = state_q.regs;
    assign command_data = state_q.cmd_data;
    assign watchdog_refresh = state_q.wd_pulse;
    assign special_mode_write = state_q.spe_pulse;
    assign mode_write = state_q.mode_pulse;
    assign debug_exit = state_q.dbg_pulse;
    assign parity_error = state_q.par_err;
    assign frame_error = state_q.frm_err;

    logic good_end;
    assign good_end = cs_rise && frame_full;

    status_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        cs_fall |=> spi_miso == $past(fixed_status[BYTE_W-1]) && spi_miso_oe)
        else $error("Fixed status bit does not lead the frame.");

    miso_release_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        cs_rise |=> !spi_miso_oe ##1 !spi_miso_oe || $past(cs_fall))
        else $error("Data line still driven after chip select rose.");

    short_frame_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        cs_rise && !frame_full |=> frame_error && $stable(reg_file))
        else $error("Bad-length frame was not discarded.");

    scratch_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_WRITE && parity_ok && reg_addr == ADDR_SCRATCH_A
        |=> state_q.regs[ADDR_SCRATCH_A] == $past(state_q.frame[BYTE_W-1:0]))
        else $error("Scratch byte did not take the written data.");

    reserved_type_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_RSVD |=> $stable(reg_file) && !mode_write)
        else $error("Reserved command changed a register.");

    parity_fail_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_WRITE && !parity_ok
        |=> parity_error && $stable(reg_file) ##1 !parity_error)
        else $error("Write with bad parity was not refused.");

    readback_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_READ && !sub_sel && reg_addr == ADDR_INIT_REGULATORS
        |=> state_q.resp == $past(state_q.regs[ADDR_INIT_REGULATORS]))
        else $error("Read-back did not return the register content.");

    random_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_READ && !sub_sel && reg_addr == ADDR_SPECIAL_MODE
        |=> state_q.resp == $past(random_code))
        else $error("Special mode read did not return the random code.");

    flag_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_FLAG && sub_sel && reg_addr == ADDR_CAN_CTRL
        |=> state_q.resp == $past(flag_high[2*BYTE_W-1:BYTE_W]))
        else $error("High flag set was not returned.");

    write_status_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_WRITE |=> state_q.resp == $past(extended_status))
        else $error("Write did not queue the extended status.");

    write_cover_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_WRITE && parity_ok);
    read_cover_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_READ);
    flag_cover_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        good_end && cmd_type == CMD_FLAG);
    short_cover_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        cs_rise && !frame_full);

endmodule : sbd_decoder

// [sbd_decoder_tb_top.sv]
// Self-checking bench of the serial command decoder.
`timescale 1ns/100ps
module sbd_decoder_tb_top;
    import sbd_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic [BYTE_W-1:0] fixed_status, extended_status, device_info, random_code, current_mode;
    logic [FLAGS_W-1:0] flag_low, flag_high;
    logic [REGS_W-1:0] reg_file, exp_rf;
    logic [BYTE_W-1:0] command_data, exp_resp;
    logic watchdog_refresh, special_mode_write, mode_write, debug_exit, parity_error, frame_error;
    logic [5:0] pulses;
    int n_p [6] = '{default: 0};
    int e_p [6] = '{default: 0};
    int err_total = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;
    assign pulses = {watchdog_refresh, special_mode_write, mode_write, debug_exit,
                     parity_error, frame_error};
    always @(posedge sys_clk) begin
        for (int k = 0; k < 6; k++) begin
            if (pulses[k] === 1'b1) n_p[k] <= n_p[k] + 1;
        end
    end

    sbd_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

    sbd_decoder dut (.sys_clk(sys_clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .fixed_status(fixed_status),
        .extended_status(extended_status), .device_info(device_info),
        .random_code(random_code), .current_mode(current_mode), .flag_low(flag_low),
        .flag_high(flag_high), .reg_file(reg_file), .command_data(command_data),
        .watchdog_refresh(watchdog_refresh), .special_mode_write(special_mode_write),
        .mode_write(mode_write), .debug_exit(debug_exit), .parity_error(parity_error),
        .frame_error(frame_error));

    task automatic check(input logic [REGS_W-1:0] seen, input logic [REGS_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // The reply to a frame comes out in the following frame.
    task automatic cmd(input logic [15:0] tx, input int n, input logic [7:0] nxt);
        logic [15:0] rx;
        @(posedge sys_clk);
        #1 fixed_status = fixed_status + 8'h3B;
        host.xfer(tx, n, rx);
        if (n >= 16) begin
            check(rx[15:8], fixed_status);
            check(rx[7:0], exp_resp);
        end
        check(spi_miso_oe, 1'b0);
        exp_resp = nxt;
    endtask : cmd

    task automatic check_state();
        check(reg_file, exp_rf);
        for (int k = 0; k < 6; k++) begin
            check(n_p[k], e_p[k]);
        end
    endtask : check_state

    task automatic test_regs();
        logic [7:0] b;
        for (int i = 0; i < 21; i++) begin
            b = 8'hA0 | 8'(i);
            cmd({2'b01, 5'(i), 1'b0, b}, 16, extended_status);
            if (i < 20 && i != 9 && i != 13) exp_rf[8*i +: 8] = b;
            if (i < 20) check(command_data, b);
            if (i == 9) e_p[4]++;
            if (i == 13) e_p[5]++;
            if (i == 14) e_p[3]++;
        end
        check_state();
        for (int i = 0; i < 21; i++) begin
            if (i == 9) b = random_code;
            else if (i == 14) b = current_mode;
            else if (i == 13 || i >= 20) b = 8'h00;
            else b = exp_rf[8*i +: 8];
            cmd({2'b00, 5'(i), 1'b1, 8'h00}, 16, b);
            if (i == 14) e_p[2]++;
        end
        check_state();
        $display("test_regs done");
    endtask : test_regs

    task automatic test_flags();
        cmd(16'h2580, 16, device_info);
        for (int k = 0; k < 5; k++) begin
            cmd({2'b11, 5'(15 + k), 2'b10, 7'h00}, 16, flag_low[8*k +: 8]);
            cmd({2'b11, 5'(15 + k), 2'b11, 7'h00}, 16, flag_high[8*k +: 8]);
        end
        cmd({2'b11, ADDR_SCRATCH_A, 2'b11, 7'h00}, 16, 8'h00);
        check_state();
        $display("test_flags done");
    endtask : test_flags

    task automatic test_parity();
        cmd({2'b01, ADDR_INIT_MISC, 1'b0, 8'h40}, 16, extended_status);
        exp_rf[8*8 +: 8] = 8'h40;
        cmd(host.with_parity({2'b01, ADDR_SCRATCH_A, 1'b0, 8'h3C}), 16, extended_status);
        exp_rf[8 +: 8] = 8'h3C;
        // A flipped parity bit must leave the store untouched.
        cmd(host.with_parity({2'b01, ADDR_SCRATCH_A, 1'b0, 8'hC3}) ^ 16'h0100, 16,
            extended_status);
        e_p[1]++;
        check(command_data, 8'h3C);
        cmd({2'b00, ADDR_SCRATCH_A, 1'b1, 8'h00}, 16, 8'h3C);
        cmd(host.with_parity({2'b01, ADDR_INIT_MISC, 1'b0, 8'h00}), 16, extended_status);
        exp_rf[8*8 +: 8] = 8'h00;
        cmd({2'b01, ADDR_SCRATCH_A, 1'b0, 8'h03}, 16, extended_status);
        exp_rf[8 +: 8] = 8'h03;
        check_state();
        $display("test_parity done");
    endtask : test_parity

    task automatic test_refused();
        cmd({2'b10, ADDR_SCRATCH_B, 1'b0, 8'hFF}, 16, 8'h00);
        cmd({2'b01, ADDR_SCRATCH_B, 1'b0, 8'h77}, 15, exp_resp);
        cmd({2'b01, ADDR_SCRATCH_B, 1'b0, 8'h77}, 17, exp_resp);
        e_p[0] += 2;
        check(command_data, 8'h03);
        check_state();
        $display("test_refused done");
    endtask : test_refused

    initial begin
        fixed_status = 8'h11;
        extended_status = 8'h5C;
        device_info = 8'hD2;
        random_code = 8'h96;
        current_mode = 8'h4B;
        flag_low = 40'h1122334455;
        flag_high = 40'hA1B2C3D4E5;
        exp_rf = '0;
        exp_resp = 8'h00;
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check(reg_file, exp_rf);
        test_regs();
        test_flags();
        test_parity();
        test_refused();
        cmd(16'h2580, 16, device_info);
        give_verdict();
    end

    // About 64 frames of about 2.26 us each are expected, so three times that is ample.
    initial begin
        #500_000;
        err_total++;
        give_verdict();
    end
endmodule : sbd_decoder_tb_top

// [sbd_host_model.sv]
// Host model that sends mode 1 command frames and collects the reply.
`timescale 1ns/100ps
module sbd_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end

    function automatic logic [15:0] with_parity(input logic [15:0] f);
        with_parity = f;
        with_parity[8] = ~^{f[15:9], f[7:0]};
    endfunction : with_parity

    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 'x;
        spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            spi_mosi = (i < 16) ? tx[15-i] : 1'b0;
            spi_sclk = 1'b1;
            #62.5;
            spi_sclk = 1'b0;
            // An undriven line reads as unknown so it can never match.
            if (i < 16) rx[15-i] = spi_miso_oe ? spi_miso : 1'bx;
            #62.5;
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #150;
    endtask : xfer
endmodule : sbd_host_model

// [sbd_pkg.sv]
// Shared constants and types of the serial register command decoder.
package sbd_pkg;

    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam int NUM_REGS = 20;
    localparam int BYTE_W = 8;
    localparam int REGS_W = NUM_REGS * BYTE_W;
    localparam int NUM_FLAG_REGS = 5;
    localparam int FLAGS_W = NUM_FLAG_REGS * BYTE_W;

    // Frame field positions.
    localparam int TYPE_HI = 15;
    localparam int TYPE_LO = 14;
    localparam int ADDR_HI = 13;
    localparam int ADDR_LO = 9;
    localparam int PN_BIT = 8;
    localparam int SUB_BIT = 7;
    localparam int PARITY_EN_BIT = 6;

    localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

    // Register addresses.
    localparam logic [4:0] ADDR_SELECTOR = 5'h00;
    localparam logic [4:0] ADDR_SCRATCH_A = 5'h01;
    localparam logic [4:0] ADDR_SCRATCH_B = 5'h02;
    localparam logic [4:0] ADDR_SCRATCH_D = 5'h04;
    localparam logic [4:0] ADDR_INIT_REGULATORS = 5'h05;
    localparam logic [4:0] ADDR_INIT_MISC = 5'h08;
    localparam logic [4:0] ADDR_SPECIAL_MODE = 5'h09;
    localparam logic [4:0] ADDR_TIMER_A = 5'h0A;
    localparam logic [4:0] ADDR_TIMER_C = 5'h0C;
    localparam logic [4:0] ADDR_WATCHDOG_REFRESH = 5'h0D;
    localparam logic [4:0] ADDR_MODE = 5'h0E;
    localparam logic [4:0] ADDR_REGULATOR_CTRL = 5'h0F;
    localparam logic [4:0] ADDR_CAN_CTRL = 5'h10;
    localparam logic [4:0] ADDR_LIN_CTRL = 5'h13;

    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_RSVD = 2'b10,
        CMD_FLAG = 2'b11
    } sbd_cmd_t;

endpackage : sbd_pkg

// [sbd_sync2.sv]
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module sbd_sync2 #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import sbd_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sbd_sync_st_t;

    sbd_sync_st_t state_q;
    sbd_sync_st_t state_d;

    always_comb begin
        state_d.s1 = async_in;
        state_d.s2 = state_q.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= {INIT, INIT};
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.s2;

endmodule : sbd_sync2
